// [atten_pkg.sv]
package atten_pkg;

  // Register offsets; printed offsets are not multiples of four, so these are
  // word indices and the byte address on a public bus would be four times this.
  localparam logic [7:0] OFS_START_WAIT = 8'hB7;
  localparam logic [7:0] OFS_ATTEN_LO = 8'hB9;
  localparam logic [7:0] OFS_ATTEN_HI = 8'hBA;
  localparam logic [7:0] OFS_FRONT_CTRL = 8'hB6;
  localparam logic [7:0] OFS_START_CTRL = 8'hB5;
  localparam logic [7:0] OFS_STATUS = 8'hBB;

  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Field positions inside the attenuation registers.
  localparam int HOLD_HI_BIT = 15;
  localparam int CODE_HI_MSB = 14;
  localparam int CODE_HI_LSB = 8;
  localparam int HOLD_LO_BIT = 7;
  localparam int CODE_LO_MSB = 6;
  localparam int CODE_LO_LSB = 0;

  // Field positions inside the front-end control register.
  localparam int OVR_BIT = 11;
  localparam int PROF_MSB = 13;
  localparam int PROF_LSB = 12;
  localparam int RES_MSB = 10;
  localparam int RES_LSB = 7;

  // Field position inside the start control register.
  localparam int INT_START_BIT = 14;

  // Input resistance codes with a special meaning.
  localparam logic [3:0] RES_50_OHM = 4'h0;
  localparam logic [3:0] RES_800_OHM = 4'h7;
  localparam logic [3:0] RES_OPEN = 4'hF;

  // Attenuation code width; level is -8 dB plus code times 0.125 dB.
  localparam int ATTEN_W = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic hold;
    logic [ATTEN_W-1:0] code;
  } profile_t;

  typedef struct packed {
    logic fixed_mode;
    logic [ATTEN_W-1:0] atten_code;
    logic input_open;
    logic [3:0] input_resistance_code;
    logic [1:0] active_profile;
  } atten_ctrl_t;

endpackage : atten_pkg

// [atten_profile_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Input resistance code selects match: 0000 50 ohm, 0111 800, 1111 open.
// - Internal start repeats with period set by the 16-bit wait field.
// - Bit 15 of first attenuation register enables hold for profile 0.
// - Bit 7 of first attenuation register enables hold for profile 1.
// - Bit 15 of second attenuation register enables hold for profile 2.
// - Bit 7 of second attenuation register enables hold for profile 3.
// - Seven-bit code N sets attenuation to -8 dB plus N times 0.125 dB.
// - A profile's code acts only while that profile's hold bit is one.
// - Profile comes from pins, or from register field when override set.
// - Start source bit picks external start or internal periodic pulse.
module atten_profile_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire atten_pkg::reg_req_t req,
  input wire logic [1:0] profile_pins,
  input wire logic ext_start,
  output logic [15:0] rdata,
  output atten_pkg::atten_ctrl_t ctrl,
  output logic tgc_start
);
  import atten_pkg::*;

  // One select line per mapped register; an unmapped offset sets none.
  typedef struct packed {
    logic start_wait;
    logic atten_lo;
    logic atten_hi;
    logic front_ctrl;
    logic start_ctrl;
    logic status;
  } reg_hit_t;

  // Every flip-flop of the block but those of u_gen; the outputs are read straight from it.
  typedef struct packed {
    logic [15:0] start_period_wait;
    logic [15:0] fixed_atten_profiles_lo;
    logic [15:0] fixed_atten_profiles_hi;
    logic [15:0] front_ctrl;
    logic [15:0] start_ctrl;
    logic [15:0] rdata;
    atten_ctrl_t ctrl;
    logic tgc_start;
  } regs_state_t;

  // Registered state, its next value and the decoded helpers.
  regs_state_t state_ff;
  regs_state_t nxt_state;
  logic int_pulse;
  profile_t prof [4];
  logic [1:0] sel;
  reg_hit_t wr_hit;
  reg_hit_t rd_hit;
  logic [15:0] rd_word;

  // Picks one profile's hold bit and code out of a register half.
  function automatic profile_t unpack_profile(input logic [15:0] word,
                                              input logic upper);
    profile_t p;
    if (upper) begin
      p.hold = word[HOLD_HI_BIT];
      p.code = word[CODE_HI_MSB:CODE_HI_LSB];
    end else begin
      p.hold = word[HOLD_LO_BIT];
      p.code = word[CODE_LO_MSB:CODE_LO_LSB];
    end
    return p;
  endfunction : unpack_profile

  // Override bit set: the register field names the profile, else the pins.
  function automatic logic [1:0] pick_profile(input logic [15:0] front,
                                              input logic [1:0] pins);
    logic [1:0] pick;
    if (front[OVR_BIT]) begin
      pick = front[PROF_MSB:PROF_LSB];
    end else begin
      pick = pins;
    end
    return pick;
  endfunction : pick_profile

  // Fixed mode forwards the profile's code; with the hold bit clear the
  // output is zero and the level is left to the gain curve.
  function automatic logic [ATTEN_W-1:0] gate_code(input profile_t p);
    logic [ATTEN_W-1:0] code;
    if (p.hold) begin
      code = p.code;
    end else begin
      code = '0;
    end
    return code;
  endfunction : gate_code

  // Only the all-ones code leaves the input unterminated; every other code
  // selects a matched source resistance.
  function automatic logic res_is_open(input logic [3:0] code);
    return code == RES_OPEN;
  endfunction : res_is_open

  // Start source: the internal generator when enabled, else the pin.
  function automatic logic pick_start(input logic use_int,
                                      input logic gen_pulse,
                                      input logic pin_start);
    logic start;
    if (use_int) begin
      start = gen_pulse;
    end else begin
      start = pin_start;
    end
    return start;
  endfunction : pick_start

  // Shared by the write and the read path so that both agree on which
  // offsets are mapped; the status offset is read-only.
  function automatic reg_hit_t decode_addr(input logic [7:0] addr);
    reg_hit_t hit;
    hit = '0;
    unique case (addr)
      OFS_START_WAIT: hit.start_wait = 1'b1;
      OFS_ATTEN_LO: hit.atten_lo = 1'b1;
      OFS_ATTEN_HI: hit.atten_hi = 1'b1;
      OFS_FRONT_CTRL: hit.front_ctrl = 1'b1;
      OFS_START_CTRL: hit.start_ctrl = 1'b1;
      OFS_STATUS: hit.status = 1'b1;
      default: hit = '0;
    endcase
    return hit;
  endfunction : decode_addr

  // Read multiplexer; a miss on every select line reads as zero.
  function automatic logic [15:0] read_mux(input reg_hit_t hit,
                                           input regs_state_t s);
    logic [15:0] word;
    word = RST_WORD;
    if (hit.start_wait) begin
      word = s.start_period_wait;
    end
    if (hit.atten_lo) begin
      word = s.fixed_atten_profiles_lo;
    end
    if (hit.atten_hi) begin
      word = s.fixed_atten_profiles_hi;
    end
    if (hit.front_ctrl) begin
      word = s.front_ctrl;
    end
    if (hit.start_ctrl) begin
      word = s.start_ctrl;
    end
    if (hit.status) begin
      word = {13'h0000, s.ctrl.fixed_mode, s.ctrl.active_profile};
    end
    return word;
  endfunction : read_mux

  // Internal periodic start generator; dropping the enable clears its
  // count, so the first pulse after enabling comes one full period later.
  start_pulse_gen u_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(state_ff.start_ctrl[INT_START_BIT]),
    .wait_time(state_ff.start_period_wait),
    .pulse(int_pulse)
  );

  // Profile table decode and active profile choice.
  always_comb begin
    prof[0] = unpack_profile(state_ff.fixed_atten_profiles_lo, 1'b1);
    prof[1] = unpack_profile(state_ff.fixed_atten_profiles_lo, 1'b0);
    prof[2] = unpack_profile(state_ff.fixed_atten_profiles_hi, 1'b1);
    prof[3] = unpack_profile(state_ff.fixed_atten_profiles_hi, 1'b0);
    sel = pick_profile(state_ff.front_ctrl, profile_pins);
  end

  // Bus decode: a low strobe masks every select line.
  assign wr_hit = req.wr ? decode_addr(req.addr) : '0;
  assign rd_hit = req.rd ? decode_addr(req.addr) : '0;
  assign rd_word = read_mux(rd_hit, state_ff);

  // Register writes, read data and registered control outputs.
  always_comb begin
    nxt_state = state_ff;
    // Read data stands for one cycle after the strobe and is zero otherwise.
    nxt_state.rdata = rd_word;
    // A write to the status offset or to an unmapped one is dropped.
    if (wr_hit.start_wait) begin
      nxt_state.start_period_wait = req.wdata;
    end
    if (wr_hit.atten_lo) begin
      nxt_state.fixed_atten_profiles_lo = req.wdata;
    end
    if (wr_hit.atten_hi) begin
      nxt_state.fixed_atten_profiles_hi = req.wdata;
    end
    if (wr_hit.front_ctrl) begin
      nxt_state.front_ctrl = req.wdata;
    end
    if (wr_hit.start_ctrl) begin
      nxt_state.start_ctrl = req.wdata;
    end
    nxt_state.ctrl.active_profile = sel;
    nxt_state.ctrl.fixed_mode = prof[sel].hold;
    nxt_state.ctrl.atten_code = gate_code(prof[sel]);
    nxt_state.ctrl.input_resistance_code =
      state_ff.front_ctrl[RES_MSB:RES_LSB];
    nxt_state.ctrl.input_open =
      res_is_open(state_ff.front_ctrl[RES_MSB:RES_LSB]);
    nxt_state.tgc_start =
      pick_start(state_ff.start_ctrl[INT_START_BIT], int_pulse, ext_start);
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs are the registered copies, never the next values.
  assign rdata = state_ff.rdata;
  assign ctrl = state_ff.ctrl;
  assign tgc_start = state_ff.tgc_start;
endmodule : atten_profile_regs
`default_nettype wire

// [atten_profile_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module atten_profile_regs_checker
  import atten_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire atten_pkg::reg_req_t req,
  input wire logic [1:0] profile_pins,
  input wire logic ext_start,
  input wire logic [15:0] rdata,
  input wire atten_pkg::atten_ctrl_t ctrl,
  input wire logic tgc_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A slot write shows in ctrl two cycles on while its profile stays on.
  property p_hold(a, p, s);
    (req.wr && req.addr == a && ctrl.active_profile == p) ##1
    (!req.wr && ctrl.active_profile == p) ##1 ctrl.active_profile == p
    |-> ctrl.fixed_mode == $past(req.wdata[s+7], 2) && ctrl.atten_code ==
    (ctrl.fixed_mode ? $past(req.wdata[s+:7], 2) : 7'h00);
  endproperty
  a_hold_p0: assert property (p_hold(OFS_ATTEN_LO, 2'h0, 8))
    else $error("profile 0 setting not applied");
  a_hold_p1: assert property (p_hold(OFS_ATTEN_LO, 2'h1, 0))
    else $error("profile 1 setting not applied");
  a_hold_p2: assert property (p_hold(OFS_ATTEN_HI, 2'h2, 8))
    else $error("profile 2 setting not applied");
  a_hold_p3: assert property (p_hold(OFS_ATTEN_HI, 2'h3, 0))
    else $error("profile 3 setting not applied");
  a_code_zero: assert property (!ctrl.fixed_mode |-> !ctrl.atten_code)
    else $error("code leaks without hold");
  a_open_code: assert property (ctrl.input_open ==
    (ctrl.input_resistance_code == RES_OPEN))
    else $error("open flag disagrees with code");
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_rd: assert property (req.rd && req.addr == 8'h00 |=> !rdata)
    else $error("unmapped read not zero");
  // Main scenarios reached.
  c_fixed: cover property (ctrl.fixed_mode);
  c_start: cover property (tgc_start);
  c_open: cover property (ctrl.input_open);
endmodule : atten_profile_regs_checker
bind atten_profile_regs atten_profile_regs_checker i_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .req(req), .profile_pins(profile_pins),
  .ext_start(ext_start), .rdata(rdata), .ctrl(ctrl), .tgc_start(tgc_start));
`default_nettype wire

// [atten_profile_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module atten_profile_regs_tb;
  import atten_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  reg_req_t req = '0;
  logic [1:0] profile_pins = 2'h0;
  logic ext_start = 1'h0;
  logic [15:0] rdata;
  atten_ctrl_t ctrl;
  logic tgc_start;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] exp_p [4] = '{8'h8A, 8'h85, 8'h00, 8'hFF};
  atten_profile_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .profile_pins(profile_pins), .ext_start(ext_start), .rdata(rdata),
    .ctrl(ctrl), .tgc_start(tgc_start));
  // The 20 MHz clock.
  always #25 sys_clk = ~sys_clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task cy(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cy
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1 chk(rdata, e);
  endtask : rd
  task t_reset;
    rd(OFS_START_WAIT, 16'h0000);
    rd(OFS_ATTEN_LO, 16'h0000);
    rd(OFS_ATTEN_HI, 16'h0000);
    rd(8'h00, 16'h0000);
    chk(16'(ctrl), 16'h0000);
  endtask : t_reset
  task t_profiles;
    for (int p = 0; p < 4; p++) begin
      @(posedge sys_clk);
      profile_pins <= p[1:0];
      cy(3);
      wr(p < 2 ? OFS_ATTEN_LO : OFS_ATTEN_HI, p < 2 ? 16'h8A85 : 16'h33FF);
      cy(3);
      chk(16'({ctrl.fixed_mode, ctrl.atten_code}), 16'(exp_p[p]));
      chk(16'(ctrl.active_profile), 16'(p[1:0]));
    end
    rd(OFS_ATTEN_LO, 16'h8A85);
    rd(OFS_ATTEN_HI, 16'h33FF);
  endtask : t_profiles
  task t_override;
    wr(OFS_FRONT_CTRL, 16'h2F80);
    cy(3);
    chk(16'(ctrl.active_profile), 16'h0002);
    chk(16'({ctrl.input_open, ctrl.input_resistance_code}), 16'h001F);
    chk(16'({ctrl.fixed_mode, ctrl.atten_code}), 16'h0000);
    rd(OFS_STATUS, 16'h0002);
    wr(OFS_FRONT_CTRL, 16'h2B80);
    cy(3);
    chk(16'({ctrl.input_open, ctrl.input_resistance_code}), 16'h0007);
    rd(OFS_FRONT_CTRL, 16'h2B80);
  endtask : t_override
  task t_start;
    wr(OFS_START_WAIT, 16'h0003);
    rd(OFS_START_WAIT, 16'h0003);
    wr(OFS_START_CTRL, 16'h4000);
    rd(OFS_START_CTRL, 16'h4000);
    cy(8);
    n = 0;
    repeat (40) begin
      cy(1);
      n += tgc_start;
    end
    chk(16'(n), 16'h000A);
    wr(OFS_START_CTRL, 16'h0000);
    cy(4);
    @(posedge sys_clk);
    ext_start <= 1'b1;
    @(posedge sys_clk);
    ext_start <= 1'b0;
    #1 chk(16'(tgc_start), 16'h0001);
    cy(1);
    chk(16'(tgc_start), 16'h0000);
  endtask : t_start
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_profiles;
    t_override;
    t_start;
    finish_test;
  end
  // Cuts a hung run short.
  initial begin
    #100us;
    miscompares++;
    finish_test;
  end
endmodule : atten_profile_regs_tb
`default_nettype wire

// [start_pulse_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module start_pulse_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [15:0] wait_time,
  output logic pulse
);
  import atten_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic pulse;
  } gen_state_t;

  gen_state_t state_ff;
  gen_state_t nxt_state;

  // Counts wait_time plus one cycles between pulses while enabled.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.pulse = 1'b0;
    if (!enable) begin
      nxt_state.count = RST_WORD;
    end else if (state_ff.count >= wait_time) begin
      nxt_state.count = RST_WORD;
      nxt_state.pulse = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pulse = state_ff.pulse;
endmodule : start_pulse_gen
`default_nettype wire
